// *** rtl/stim_chassis_node.sv ***
`timescale 1ns/1ps
`include "stim_consts.svh"

// Operation
// R1: Engine node reports speed on 0.2 kph change, never closer than 100 ms.
// R2: Speed pacing table: 0.2 kph with 100 ms, 0.5 kph with 500 ms.
// R3: Engine node keeps speed delta and repeat interval as calibrations.
// R4: Failure speed report payload is ignored; only its arrival matters.
// R5: Speed is unsigned 16 bits, 1/128 kph per count, 0 to 511.99 kph.
// R6: Engine speed request and report headers are fixed byte sequences.
// R7: Chassis accepts normal speed report X8 29 XX 02.
// R8: Chassis accepts failure speed report X8 29 XX 42.
// R9: Drop any message whose first header byte has odd upper nibble.
// R10: Speed and request receive actions only act in run mode.
// R11: Chassis sends inhibit report on flag change, at least 100 ms apart.
// R12: Inhibit request, acknowledge and report headers are fixed sequences.
// R13: Engine accepts inhibit reports and acknowledges each one.
// R14: Acknowledge X9 2A XX 47 stops retries; otherwise keep retrying.
// R15: Flag set on brake overtemperature, disable press or detected fault.
// R16: Flag cleared when none of the disabling causes are present.
// R17: Engine suspends torque input diagnostics while traction disabled.
// R18: Engine treats inhibit as invalid until first valid report.
module stim_chassis_node
  import stim_pkg::*;
#(
  parameter int MIN_REP_CYC = `STIM_MIN_REP_CYC,
  parameter logic [7:0] OWN_ADDR = `STIM_OWN_ADDR
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic run_mode_in,
  input wire logic brake_overtemp_in,
  input wire logic switch_press_in,
  input wire logic fault_in,
  input wire logic speed_req_in,
  input wire stim_msg_t rx_msg_in,
  input wire logic rx_valid_in,
  input wire logic tx_ready_in,
  output stim_msg_t tx_msg_out,
  output logic tx_valid_out,
  output logic [15:0] speed_out,
  output logic speed_valid_out,
  output logic speed_fail_out,
  output logic inhibit_flag_out,
  output logic ack_pending_out
);

  localparam int W = `STIM_TMR_W;
  localparam logic [W-1:0] GAP_MIN = W'(MIN_REP_CYC - 1);
  default clocking dflt_cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_m_r;
  logic [3:0] pin_s_r;
  logic run_s;
  logic brake_s;
  logic sw_s;
  logic fault_s;
  logic sw_d_r;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_m_r <= 4'h0;
      pin_s_r <= 4'h0;
      sw_d_r <= 1'b0;
    end else begin
      pin_m_r <= {run_mode_in, brake_overtemp_in, switch_press_in, fault_in};
      pin_s_r <= pin_m_r;
      sw_d_r <= pin_s_r[1];
    end
  end

  assign run_s = pin_s_r[3];
  assign brake_s = pin_s_r[2];
  assign sw_s = pin_s_r[1];
  assign fault_s = pin_s_r[0];

  // ----------------------------------------------------------------
  // Inhibit flag
  // ----------------------------------------------------------------
  logic disable_r;
  logic inhibit_r;
  logic inhibit_nxt;

  // Each press toggles between disabling and reactivating
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      disable_r <= 1'b0;
    end else if (sw_s && !sw_d_r) begin
      disable_r <= !disable_r;
    end
  end

  assign inhibit_nxt = brake_s || disable_r || fault_s; // [R15] [R16]

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      inhibit_r <= 1'b0;
    end else begin
      inhibit_r <= inhibit_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Receive decode
  // ----------------------------------------------------------------
  logic rx_ok;
  logic rx_rpt;
  logic rx_req;
  logic hit_speed;
  logic hit_fail;
  logic hit_inh_req;
  logic hit_ack;

  assign rx_ok = rx_valid_in && run_s &&
                 !rx_msg_in.b0[`STIM_EVEN_BIT]; // [R9] [R10]
  assign rx_rpt = rx_ok && (rx_msg_in.b0[3:0] == `STIM_NIB_RPT);
  assign rx_req = rx_ok && (rx_msg_in.b0[3:0] == `STIM_NIB_REQ);
  assign hit_speed = rx_rpt && (rx_msg_in.b1 == `STIM_TGT_SPEED_RPT) &&
                     (rx_msg_in.b3 == `STIM_EXT_SPEED); // [R7]
  assign hit_fail = rx_rpt && (rx_msg_in.b1 == `STIM_TGT_SPEED_RPT) &&
                    (rx_msg_in.b3 == `STIM_EXT_SPEED_FAIL); // [R8]
  assign hit_inh_req = rx_req && (rx_msg_in.b1 == `STIM_TGT_INH_CMD) &&
                       (rx_msg_in.b3 == `STIM_EXT_INH_REQ); // [R12]
  assign hit_ack = rx_req && (rx_msg_in.b1 == `STIM_TGT_INH_CMD) &&
                   (rx_msg_in.b3 == `STIM_EXT_INH_ACK); // [R14]

  logic [15:0] speed_r;
  logic speed_valid_r;
  logic speed_fail_r;

  // Failure payload never reaches the speed output
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      speed_r <= 16'h0000;
      speed_valid_r <= 1'b0;
      speed_fail_r <= 1'b0;
    end else begin
      speed_valid_r <= hit_speed; // [R7]
      speed_fail_r <= hit_fail; // [R4] [R8]
      if (hit_speed) begin
        speed_r <= rx_msg_in.data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit scheduling
  // ----------------------------------------------------------------
  logic expired;
  logic launch_rpt;
  logic launch_sreq;
  logic need_send;
  logic pending_r;
  logic sent_flag_r;
  logic inh_req_r;
  logic sreq_r;
  logic tx_valid_r;
  stim_msg_t tx_msg_r;

  stim_timer #(
    .W(W),
    .TICKS(MIN_REP_CYC)
  ) u_rep_timer (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .start_in(launch_rpt),
    .expired_out(expired)
  );

  // Unacked, changed or requested; retries are paced like changes
  assign need_send = pending_r || (inhibit_r != sent_flag_r) || inh_req_r;
  assign launch_rpt = run_s && expired && !tx_valid_r && need_send; // [R11]
  assign launch_sreq = run_s && !tx_valid_r && !launch_rpt && sreq_r;

  // A launch in the same cycle as an ack wins, keeping the retry alive
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pending_r <= 1'b1;
      sent_flag_r <= 1'b0;
    end else if (launch_rpt) begin
      pending_r <= 1'b1;
      sent_flag_r <= inhibit_r;
    end else if (hit_ack) begin
      pending_r <= 1'b0; // [R14]
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      inh_req_r <= 1'b0;
    end else if (hit_inh_req) begin
      inh_req_r <= 1'b1;
    end else if (launch_rpt) begin
      inh_req_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sreq_r <= 1'b0;
    end else if (speed_req_in) begin
      sreq_r <= 1'b1;
    end else if (launch_sreq) begin
      sreq_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_valid_r <= 1'b0;
      tx_msg_r <= '0;
    end else if (tx_valid_r) begin
      if (tx_ready_in) begin
        tx_valid_r <= 1'b0;
      end
    end else if (launch_rpt) begin
      tx_valid_r <= 1'b1;
      tx_msg_r.b0 <= `STIM_PRIO_RPT;
      tx_msg_r.b1 <= `STIM_TGT_INH_RPT;
      tx_msg_r.b2 <= OWN_ADDR;
      tx_msg_r.b3 <= inhibit_r ? `STIM_EXT_INH_Q1 : `STIM_EXT_INH_Q0; // [R12]
      tx_msg_r.data <= 16'h0000;
    end else if (launch_sreq) begin
      tx_valid_r <= 1'b1;
      tx_msg_r.b0 <= `STIM_PRIO_SREQ;
      tx_msg_r.b1 <= `STIM_TGT_SPEED_REQ;
      tx_msg_r.b2 <= OWN_ADDR;
      tx_msg_r.b3 <= `STIM_EXT_SPEED;
      tx_msg_r.data <= 16'h0000;
    end
  end

  assign tx_msg_out = tx_msg_r;
  assign tx_valid_out = tx_valid_r;
  assign speed_out = speed_r;
  assign speed_valid_out = speed_valid_r;
  assign speed_fail_out = speed_fail_r;
  assign inhibit_flag_out = inhibit_r;
  assign ack_pending_out = pending_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [W-1:0] gap_r;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap_r <= '1;
    end else if (launch_rpt) begin
      gap_r <= '0;
    end else if (gap_r != '1) begin
      gap_r <= gap_r + 1'b1;
    end
  end

  odd_nibble_a: assert property ( // [R9]
    rx_valid_in && rx_msg_in.b0[4] |=> !speed_valid_out && !speed_fail_out)
    else $error("odd header nibble accepted");
  run_gate_a: assert property ( // [R10]
    rx_valid_in && !run_s |=> !speed_valid_out && !speed_fail_out)
    else $error("message acted on outside run mode");
  speed_take_a: assert property ( // [R7]
    hit_speed |=> speed_valid_out && speed_out == $past(rx_msg_in.data))
    else $error("speed report not taken");
  fail_keep_a: assert property ( // [R4] [R8]
    hit_fail |=> speed_fail_out && $stable(speed_out))
    else $error("failure report disturbed speed");
  rep_space_a: assert property ( // [R11]
    launch_rpt |-> gap_r >= GAP_MIN)
    else $error("inhibit reports too close");
  rpt_header_a: assert property ( // [R12]
    launch_rpt |=> tx_valid_out && tx_msg_out.b1 == `STIM_TGT_INH_RPT &&
      tx_msg_out.b3[7] == $past(inhibit_r))
    else $error("inhibit report header wrong");
  ack_stop_a: assert property ( // [R14]
    hit_ack && !launch_rpt && inhibit_r == sent_flag_r && !inh_req_r &&
      !hit_inh_req && inhibit_nxt == inhibit_r |=> !launch_rpt)
    else $error("retry after acknowledge");
  flag_set_a: assert property ( // [R15]
    fault_s || brake_s |=> inhibit_flag_out)
    else $error("inhibit flag not set");
  flag_clr_a: assert property ( // [R16]
    !fault_s && !brake_s && !disable_r |=> !inhibit_flag_out)
    else $error("inhibit flag not cleared");
  change_send_a: assert property ( // [R11]
    run_s && expired && !tx_valid_r && inhibit_r != sent_flag_r
      |=> tx_valid_out && tx_msg_out.b0 == `STIM_PRIO_RPT)
    else $error("flag change not reported");

endmodule

// *** rtl/stim_consts.svh ***
`ifndef STIM_CONSTS_SVH
`define STIM_CONSTS_SVH

// ----------------------------------------------------------------
// Header bytes
// ----------------------------------------------------------------
`define STIM_NIB_RPT 4'h8
`define STIM_NIB_REQ 4'h9
`define STIM_EVEN_BIT 4
`define STIM_PRIO_RPT 8'h88
`define STIM_PRIO_SREQ 8'ha9
`define STIM_TGT_SPEED_REQ 8'h28
`define STIM_TGT_SPEED_RPT 8'h29
`define STIM_TGT_INH_CMD 8'h2a
`define STIM_TGT_INH_RPT 8'h2b
`define STIM_EXT_SPEED 8'h02
`define STIM_EXT_SPEED_FAIL 8'h42
`define STIM_EXT_INH_REQ 8'h07
`define STIM_EXT_INH_ACK 8'h47
`define STIM_EXT_INH_Q0 8'h07
`define STIM_EXT_INH_Q1 8'h87
`define STIM_OWN_ADDR 8'h40

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define STIM_CLK_KHZ 10000
`define STIM_MIN_REP_MS 100
`define STIM_MIN_REP_CYC (`STIM_MIN_REP_MS * `STIM_CLK_KHZ)
`define STIM_TMR_W 20

`endif

// *** rtl/stim_pkg.sv ***
package stim_pkg;

  // ----------------------------------------------------------------
  // Message carrier: four header bytes and a 16-bit payload
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [15:0] data;
  } stim_msg_t;

endpackage

// *** rtl/stim_timer.sv ***
`timescale 1ns/1ps
`include "stim_consts.svh"

module stim_timer
  import stim_pkg::*;
#(
  parameter int W = `STIM_TMR_W,
  parameter int TICKS = `STIM_MIN_REP_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  output logic expired_out
);

  localparam logic [W-1:0] TICKS_M1 = W'(TICKS - 1);

  logic [W-1:0] count_r;

  // ----------------------------------------------------------------
  // Countdown; expired from reset so the first send is not held off
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_r <= '0;
    end else if (start_in) begin
      count_r <= TICKS_M1;
    end else if (count_r != '0) begin
      count_r <= count_r - 1'b1;
    end
  end

  assign expired_out = (count_r == '0);

endmodule

// *** verification/stim_chassis_node_tb.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// Bench top
// ----------------------------------------
module stim_chassis_node_tb
  import stim_pkg::*;
;
  localparam int REP = 20;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic run_mode_in = 1'b1;
  logic brake_overtemp_in = 1'b0;
  logic switch_press_in = 1'b0;
  logic fault_in = 1'b0;
  logic speed_req_in = 1'b0;
  logic ack_en = 1'b0;
  logic slow = 1'b0;
  stim_msg_t rx_msg_in, tx_msg_out;
  logic rx_valid_in, tx_ready_in, tx_valid_out;
  logic speed_valid_out, speed_fail_out, inhibit_flag_out;
  logic ack_pending_out, flag_ok, flag_seen;
  logic [15:0] speed_out;
  logic exp_sv = 1'b0;
  logic exp_sf = 1'b0;
  logic [15:0] exp_spd = 16'h0000;
  logic prev_v = 1'b0;
  logic [7:0] last_b3 = 8'h00;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int last_l = -1000;
  int n_rpt = 0;
  int n_req = 0;
  int base_rpt = 0;
  bit [31:0] lf = 32'h749ace8e;

  always #50 mclk_in = ~mclk_in;

  stim_chassis_node #(.MIN_REP_CYC(REP)) u_dut (
    .mclk_in, .rst_n_in, .run_mode_in, .brake_overtemp_in,
    .switch_press_in, .fault_in, .speed_req_in, .rx_msg_in,
    .rx_valid_in, .tx_ready_in, .tx_msg_out, .tx_valid_out, .speed_out,
    .speed_valid_out, .speed_fail_out, .inhibit_flag_out, .ack_pending_out
  );

  stim_engine_model #(.REP(REP)) u_eng (
    .mclk_in, .rst_n_in, .msg_in(tx_msg_out), .valid_in(tx_valid_out),
    .ack_en_in(ack_en), .slow_in(slow), .ready_out(tx_ready_in),
    .rx_msg_out(rx_msg_in), .rx_valid_out(rx_valid_in),
    .flag_ok_out(flag_ok), .flag_out(flag_seen)
  );

  function automatic bit [31:0] lfsr(input bit [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [47:0] e,
                     input logic [47:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic drain();
    for (int k = 0; k < 40 * REP && u_eng.q.size() > 0; k++)
      @(negedge mclk_in);
    repeat (REP + 6) @(negedge mclk_in);
  endtask

  // Reference receiver and transmit monitor
  always @(posedge mclk_in) begin
    exp_sv <= 1'b0;
    exp_sf <= 1'b0;
    if (!rst_n_in) begin
      exp_spd <= 16'h0000;
    end else if (rx_valid_in && run_mode_in && !rx_msg_in.b0[4]
                 && rx_msg_in.b0[3:0] == 4'h8 && rx_msg_in.b1 == 8'h29) begin
      exp_sv <= rx_msg_in.b3 == 8'h02;
      exp_sf <= rx_msg_in.b3 == 8'h42;
      if (rx_msg_in.b3 == 8'h02)
        exp_spd <= rx_msg_in.data;
    end
    cyc <= cyc + 1;
    prev_v <= tx_valid_out;
    if (tx_valid_out && !prev_v && tx_msg_out.b0 == 8'h88) begin
      chk("report spacing", 48'd1, 48'(cyc - last_l >= REP));
      last_l <= cyc;
    end
    if (tx_valid_out && tx_ready_in) begin
      if (tx_msg_out.b0 == 8'ha9) begin
        n_req++;
        chk("request msg", 48'ha9284002_0000, tx_msg_out);
      end else begin
        n_rpt++;
        last_b3 <= tx_msg_out.b3;
        chk("report msg", {24'h882b40, 1'b1, 16'h0}, {tx_msg_out[47:24],
            tx_msg_out.b3 === 8'h07 || tx_msg_out.b3 === 8'h87,
            tx_msg_out.data});
      end
    end
  end

  always @(negedge mclk_in) begin
    chk("speed pulse", 48'(exp_sv), 48'(speed_valid_out));
    chk("fail pulse", 48'(exp_sf), 48'(speed_fail_out));
    chk("speed value", 48'(exp_spd), 48'(speed_out));
  end

  initial begin
    #(100 * 150 * REP);
    err_count++;
    close_out();
  end

  initial begin
    repeat (12) @(negedge mclk_in);
    rst_n_in = 1'b1;
    repeat (5 * REP) @(negedge mclk_in);
    chk("retries", 48'd5, 48'(n_rpt));
    chk("pending", 48'd1, 48'(ack_pending_out));
    ack_en = 1'b1;
    repeat (3 * REP) @(negedge mclk_in);
    chk("acked", 48'd0, 48'(ack_pending_out));
    chk("model valid", 48'd1, 48'(flag_ok));
    $display("test startup done");
    for (int i = 0; i < 6; i++) begin
      slow = i[0];
      case (i)
        0, 1: fault_in = !fault_in;
        2, 3: brake_overtemp_in = !brake_overtemp_in;
        default: begin
          switch_press_in = 1'b1;
          repeat (3) @(negedge mclk_in);
          switch_press_in = 1'b0;
        end
      endcase
      repeat (4 * REP) @(negedge mclk_in);
      chk("flag", 48'(i[0] == 0), 48'(inhibit_flag_out));
      chk("flag sent", 48'(i[0] == 0), 48'(last_b3[7]));
      chk("flag seen", 48'(i[0] == 0), 48'(flag_seen));
      chk("flag acked", 48'd0, 48'(ack_pending_out));
    end
    $display("test flags done");
    for (int i = 0; i < 18; i++) begin
      lf = lfsr(lf);
      u_eng.q.push_back({i < 16 ? i[3:0] : 4'h2, 4'h8, 8'h29, lf[7:0],
          i < 16 ? 8'h02 : (i == 16 ? 8'h42 : 8'h03), lf[31:16]});
    end
    drain();
    run_mode_in = 1'b0;
    repeat (6) @(negedge mclk_in);
    u_eng.q.push_back({8'h88, 8'h29, 8'h10, 8'h02, 16'h5555});
    drain();
    run_mode_in = 1'b1;
    repeat (6) @(negedge mclk_in);
    $display("test speed receive done");
    speed_req_in = 1'b1;
    @(negedge mclk_in);
    speed_req_in = 1'b0;
    repeat (REP) @(negedge mclk_in);
    chk("request sent", 48'd1, 48'(n_req));
    $display("test speed request done");
    base_rpt = n_rpt;
    u_eng.q.push_back({8'hd9, 8'h2a, 8'h10, 8'h07, 16'h0000});
    u_eng.q.push_back({8'hc9, 8'h2a, 8'h10, 8'h07, 16'h0000});
    repeat (2 * REP) @(negedge mclk_in);
    chk("request report", 48'(base_rpt + 1), 48'(n_rpt));
    chk("request acked", 48'd0, 48'(ack_pending_out));
    chk("request flag", 48'd0, 48'(last_b3[7]));
    $display("test inhibit request done");
    close_out();
  end
endmodule

// *** verification/stim_engine_model.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// Engine-side node model
// ----------------------------------------
module stim_engine_model
  import stim_pkg::*;
#(
  parameter int REP = 20
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire stim_msg_t msg_in,
  input wire logic valid_in,
  input wire logic ack_en_in,
  input wire logic slow_in,
  output logic ready_out,
  output stim_msg_t rx_msg_out,
  output logic rx_valid_out,
  output logic flag_ok_out,
  output logic flag_out
);
  stim_msg_t q[$];
  int gap = REP;
  int rc = 0;
  wire logic take = valid_in && ready_out && !msg_in.b0[4];

  initial begin
    ready_out = 1'b0;
    rx_msg_out = '0;
    rx_valid_out = 1'b0;
    flag_ok_out = 1'b0;
    flag_out = 1'b0;
  end

  always @(negedge mclk_in) begin
    gap++;
    rc = (rc + 1) % 4;
    ready_out <= !slow_in || rc == 0;
    // Speed reports wait out the minimum repeat interval
    if (q.size() > 0 && (q[0].b1 != 8'h29 || gap >= REP)) begin
      if (q[0].b1 == 8'h29)
        gap = 0;
      rx_msg_out <= q.pop_front();
      rx_valid_out <= 1'b1;
    end else begin
      // Idle lines toggle so stale data never looks valid
      rx_msg_out <= ~rx_msg_out;
      rx_valid_out <= 1'b0;
    end
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_ok_out <= 1'b0;
    end else if (take && msg_in.b0[3:0] == 4'h8 && msg_in.b1 == 8'h2b
                 && msg_in.b3[6:0] == 7'h07) begin
      flag_out <= msg_in.b3[7];
      flag_ok_out <= 1'b1;
      if (ack_en_in)
        q.push_back({8'ha9, 8'h2a, 8'h10, 8'h47, 16'h0000});
    end
  end
endmodule
